// ===== rx_queue_address_pointers.sv
/*
  Receive queue address generation and pointer keeping: free (pending) queue
  filled by the host, ready (release) queue filled by the device, descriptor
  address forming and receive option bits. Assumes a single 40 MHz clock, a
  16-bit control port with one-cycle strobes and read data the cycle after,
  and a memory port that answers each entry read with a one-cycle valid.
  The ready queue read pointer is kept here only so that posts can tell a
  full queue from an empty one; reading the ready entries is left to the
  host. Nothing here raises an interrupt beyond the one-cycle post pulse.
  Register indices and field positions come from the shared defines header.
*/
// The address map and strobed register access are this design's own decisions.
// How it works
// - Base register gives the top 10 address bits of both queues.
// - Queue address is base shifted 14 over offset shifted 1, 24 bits.
// - Bit 0 of every queue entry address is always zero.
// - Non-assured mode still delivers trailer payload of AAL5 packets failing CRC.
// - First-cell streaming posts the descriptor after cell one and raises interrupt.
// - Keep-MID bit makes AAL3/4 cells with non-zero MID be accepted.
// - Free start offset marks the lowest pending queue address.
// - Free end offset marks the last pending queue address.
// - Pointer write with top data bit set increments instead of loading.
// - Pointer read shows empty when pointers match and queue holds nothing.
// - Pointer read shows full when pointers match and queue is full.
// - Device fetches references at its free read pointer, read-only to host.
// - Descriptor address is table base shifted 8 plus index shifted 5.
// - Ready start offset marks the lowest release queue address.
// - Ready end offset marks the last release queue address.
// - After reassembly the device writes the descriptor at ready write pointer.
`timescale 1ns/1ps
module rx_queue_address_pointers (
  // Clock and reset.
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  // Control register port.
  input wire rxq_pkg::reg_req_type REG_REQ_I,
  output logic [15:0] REG_RDATA_O,
  // Reassembly side requests.
  input wire logic FETCH_REQ_I,
  input wire logic PACKET_DONE_I,
  input wire logic FIRST_CELL_DONE_I,
  input wire logic [11:0] DONE_DESC_IDX_I,
  input wire logic CRC_FAIL_I,
  input wire logic TRAILER_CELL_I,
  input wire logic MID_NONZERO_I,
  input wire logic AAL34_CELL_I,
  // Memory port towards the queues.
  output logic MEM_RD_O,
  output logic MEM_WR_O,
  output logic [23:0] MEM_ADDR_O,
  output logic [15:0] MEM_WDATA_O,
  input wire logic MEM_RVALID_I,
  input wire logic [15:0] MEM_RDATA_I,
  // Results to the reassembly logic.
  output logic FETCH_VALID_O,
  output logic FETCH_NONE_O,
  output logic [23:0] FETCH_DESC_ADDR_O,
  output logic READY_WRITE_IRQ_O,
  output logic READY_FULL_O,
  output logic TRAILER_DMA_EN_O,
  output logic CELL_DISCARD_O,
  output rxq_pkg::rx_opts_type OPTS_O
);
  import rxq_pkg::*;

  // Configuration and pointer state. Offsets and pointers keep only the 13
  // bits that a queue region can address; the upper data bits of the pointer
  // registers carry flags on read-back and are never stored.
  logic [15:0] base_opt_reg;
  logic [12:0] free_start_reg;
  logic [12:0] free_end_reg;
  logic [12:0] free_wptr_reg;
  logic [12:0] free_rptr_reg;
  logic [15:0] desc_base_reg;
  logic [12:0] ready_start_reg;
  logic [12:0] ready_end_reg;
  logic [12:0] ready_wptr_reg;
  logic [12:0] ready_rptr_reg;
  logic free_full_reg;
  logic ready_full_reg;
  logic [15:0] rdata_reg;
  fetch_state_type fetch_reg;
  logic [23:0] fetch_addr_reg;
  logic fetch_valid_reg;
  logic fetch_none_reg;
  logic mem_rd_reg;
  logic mem_wr_reg;
  logic [23:0] mem_addr_reg;
  logic [15:0] mem_wdata_reg;
  logic irq_reg;

  // Decoded strobes and helpers. None of them is stored, so a register write
  // moves the queue pointers at the same edge that latches it.
  logic [9:0] qbase;
  logic wr_hit_free_w;
  logic wr_hit_ready_r;
  logic [12:0] free_w_next;
  logic [12:0] ready_r_next;
  logic free_push;
  logic free_pop;
  logic ready_push;
  logic ready_pop;
  logic free_empty;
  logic ready_empty;

  // Step one pointer forward, wrapping at the end of its region.
  // A pointer outside start..end is never pulled back into range, so software
  // must program both offsets before it moves any pointer.
  function automatic logic [12:0] advance(input logic [12:0] ptr, input logic [12:0] first,
                                          input logic [12:0] last);
    advance = (ptr == last) ? first : ptr + 13'h0001;
  endfunction

  // Entry address: base over pointer, halfword aligned.
  // Base and offset fields do not overlap, so an OR joins them; bit 0 is
  // cleared once more so that no change of the shifts can leave an odd
  // address on the memory port.
  function automatic logic [23:0] entry_addr(input logic [9:0] base, input logic [12:0] ofs);
    logic [23:0] wide;
    wide = 24'h000000;
    wide = {base, 14'h0000} | {10'h000, ofs, 1'b0};
    entry_addr = {wide[23:1], 1'b0};
  endfunction

  // The base field sits in the ten low bits of the base and option register.
  // Both queues share it, so the two regions live in one 16 K byte window.
  assign qbase = base_opt_reg[`RXQ_BASE_W-1:0];

  // Pointer writes from the host, with auto-increment on the top data bit.
  // The same decode feeds the pointer update and the full flag, so a loaded
  // pointer and an incremented one are treated alike.
  assign wr_hit_free_w = REG_REQ_I.wr && (REG_REQ_I.addr == `RXQ_IDX_FREE_WPTR);
  assign wr_hit_ready_r = REG_REQ_I.wr && (REG_REQ_I.addr == `RXQ_IDX_READY_RPTR);
  assign free_w_next = REG_REQ_I.wdata[`RXQ_BIT_AUTO_INC] ?
                       advance(free_wptr_reg, free_start_reg, free_end_reg) :
                       REG_REQ_I.wdata[12:0];
  assign ready_r_next = REG_REQ_I.wdata[`RXQ_BIT_AUTO_INC] ?
                        advance(ready_rptr_reg, ready_start_reg, ready_end_reg) :
                        REG_REQ_I.wdata[12:0];

  // Equal pointers mean empty unless the last move was a push.
  // A host pointer that lands on the read pointer is taken as a full queue,
  // so software must never post more entries than the region can hold.
  assign free_empty = (free_wptr_reg == free_rptr_reg) && !free_full_reg;
  assign ready_empty = (ready_wptr_reg == ready_rptr_reg) && !ready_full_reg;
  assign free_push = wr_hit_free_w;
  assign free_pop = (fetch_reg == FETCH_WAIT) && MEM_RVALID_I;
  assign ready_push = (PACKET_DONE_I || (FIRST_CELL_DONE_I &&
                      base_opt_reg[`RXQ_BIT_FIRST_CELL_IRQ])) && !ready_full_reg;
  assign ready_pop = wr_hit_ready_r;

  // Plain configuration registers.
  // Bit 10 of the base register is unused and always reads back as zero.
  // Writes to the read-only pointer indices fall into the empty default arm.
  // A start or end offset change takes effect at once, even mid-queue.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      base_opt_reg <= `RXQ_RESET_WORD;
      free_start_reg <= `RXQ_RESET_OFS;
      free_end_reg <= `RXQ_RESET_OFS;
      desc_base_reg <= `RXQ_RESET_WORD;
      ready_start_reg <= `RXQ_RESET_OFS;
      ready_end_reg <= `RXQ_RESET_OFS;
    end else if (REG_REQ_I.wr) begin
      unique case (REG_REQ_I.addr)
        `RXQ_IDX_BASE_OPT: base_opt_reg <= REG_REQ_I.wdata & 16'hfbff;
        `RXQ_IDX_FREE_START: free_start_reg <= REG_REQ_I.wdata[12:0];
        `RXQ_IDX_FREE_END: free_end_reg <= REG_REQ_I.wdata[12:0];
        `RXQ_IDX_DESC_BASE: desc_base_reg <= REG_REQ_I.wdata;
        `RXQ_IDX_READY_START: ready_start_reg <= REG_REQ_I.wdata[12:0];
        `RXQ_IDX_READY_END: ready_end_reg <= REG_REQ_I.wdata[12:0];
        default: ;
      endcase
    end
  end

  // Free queue: host writes, device reads. A full flag tells equal pointers apart.
  // Writing the start offset restarts the queue empty; it, or a plain load of the
  // write pointer, recovers a pointer that software has set outside the region.
  // A push and a pop in the same cycle leave the fill state as it was.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      free_wptr_reg <= `RXQ_RESET_OFS;
      free_rptr_reg <= `RXQ_RESET_OFS;
      free_full_reg <= 1'b0;
    end else begin
      if (REG_REQ_I.wr && REG_REQ_I.addr == `RXQ_IDX_FREE_START) begin
        free_wptr_reg <= REG_REQ_I.wdata[12:0];
        free_rptr_reg <= REG_REQ_I.wdata[12:0];
        free_full_reg <= 1'b0;
      end else begin
        if (free_push) begin
          free_wptr_reg <= free_w_next;
        end
        if (free_pop) begin
          free_rptr_reg <= advance(free_rptr_reg, free_start_reg, free_end_reg);
        end
        if (free_push && !free_pop) begin
          free_full_reg <= (free_w_next == free_rptr_reg);
        end else if (free_pop && !free_push) begin
          free_full_reg <= 1'b0;
        end
      end
    end
  end

  // Ready queue: device writes, host reads.
  // A post that meets a full queue is already refused in ready_push, so the
  // full flag is only cleared by a host move of the read pointer or a restart.
  // Posts and host pops in one cycle leave the fill state unchanged.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ready_wptr_reg <= `RXQ_RESET_OFS;
      ready_rptr_reg <= `RXQ_RESET_OFS;
      ready_full_reg <= 1'b0;
    end else begin
      if (REG_REQ_I.wr && REG_REQ_I.addr == `RXQ_IDX_READY_START) begin
        ready_wptr_reg <= REG_REQ_I.wdata[12:0];
        ready_rptr_reg <= REG_REQ_I.wdata[12:0];
        ready_full_reg <= 1'b0;
      end else begin
        if (ready_push) begin
          ready_wptr_reg <= advance(ready_wptr_reg, ready_start_reg, ready_end_reg);
        end
        if (ready_pop) begin
          ready_rptr_reg <= ready_r_next;
        end
        if (ready_push && !ready_pop) begin
          ready_full_reg <= (advance(ready_wptr_reg, ready_start_reg, ready_end_reg)
                             == ready_rptr_reg);
        end else if (ready_pop && !ready_push) begin
          ready_full_reg <= 1'b0;
        end
      end
    end
  end

  // Free queue fetch: read the entry at the read pointer, then form the address.
  // The entry read is issued only from FETCH_ADDR. A ready post that takes the
  // memory port in that cycle keeps the machine there, so the read is delayed
  // by one cycle instead of being lost and leaving FETCH_WAIT without an answer.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      fetch_reg <= FETCH_IDLE;
      fetch_valid_reg <= 1'b0;
      fetch_none_reg <= 1'b0;
      fetch_addr_reg <= 24'h000000;
    end else begin
      fetch_valid_reg <= 1'b0;
      fetch_none_reg <= 1'b0;
      unique case (fetch_reg)
        // Idle: an empty queue answers at once with a one-cycle none pulse.
        FETCH_IDLE: begin
          if (FETCH_REQ_I) begin
            if (free_empty) begin
              fetch_none_reg <= 1'b1;
            end else begin
              fetch_reg <= FETCH_ADDR;
            end
          end
        end
        // Address: the read goes out unless a post holds the memory port.
        FETCH_ADDR: begin
          if (!ready_push) begin
            fetch_reg <= FETCH_WAIT;
          end
        end
        // Wait: the memory answer is turned into a descriptor address.
        FETCH_WAIT: begin
          if (MEM_RVALID_I) begin
            fetch_addr_reg <= {desc_base_reg, 8'h00} +
                              {7'h00, MEM_RDATA_I[11:0], 5'h00};
            fetch_valid_reg <= 1'b1;
            fetch_reg <= FETCH_IDLE;
          end
        end
      endcase
    end
  end

  // Memory port: a ready queue post takes priority over a fetch read.
  // Posts win because a lost post loses a finished packet, whereas a fetch
  // read can simply wait one cycle. The write data carries only the index.
  // Address and data hold their last values; only the strobes return to zero.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      mem_addr_reg <= 24'h000000;
      mem_wdata_reg <= 16'h0000;
      irq_reg <= 1'b0;
    end else begin
      mem_rd_reg <= 1'b0;
      mem_wr_reg <= 1'b0;
      irq_reg <= 1'b0;
      if (ready_push) begin
        mem_wr_reg <= 1'b1;
        mem_addr_reg <= entry_addr(qbase, ready_wptr_reg);
        mem_wdata_reg <= {4'h0, DONE_DESC_IDX_I};
        irq_reg <= 1'b1;
      end else if (fetch_reg == FETCH_ADDR) begin
        mem_rd_reg <= 1'b1;
        mem_addr_reg <= entry_addr(qbase, free_rptr_reg);
      end
    end
  end

  // Register read-back, answered the cycle after the strobe.
  // Unmapped indices and idle cycles return zero, so a stale value is never
  // mistaken for a fresh answer. Bit 13 of the read-only pointers shows the
  // async option bit that software set for that clock.
  always_ff @(posedge CLK_SYS_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rdata_reg <= 16'h0000;
    end else if (REG_REQ_I.rd) begin
      unique case (REG_REQ_I.addr)
        `RXQ_IDX_BASE_OPT: rdata_reg <= base_opt_reg;
        `RXQ_IDX_FREE_START: rdata_reg <= {3'h0, free_start_reg};
        `RXQ_IDX_FREE_END: rdata_reg <= {3'h0, free_end_reg};
        `RXQ_IDX_FREE_WPTR: rdata_reg <= {1'b0, free_empty, free_full_reg,
                                          free_wptr_reg};
        `RXQ_IDX_FREE_RPTR: rdata_reg <= {2'h0, base_opt_reg[`RXQ_BIT_ASYNC_DMA],
                                          free_rptr_reg};
        `RXQ_IDX_DESC_BASE: rdata_reg <= desc_base_reg;
        `RXQ_IDX_READY_START: rdata_reg <= {3'h0, ready_start_reg};
        `RXQ_IDX_READY_END: rdata_reg <= {3'h0, ready_end_reg};
        `RXQ_IDX_READY_WPTR: rdata_reg <= {2'h0, base_opt_reg[`RXQ_BIT_ASYNC_RX],
                                           ready_wptr_reg};
        `RXQ_IDX_READY_RPTR: rdata_reg <= {1'b0, ready_empty, ready_full_reg,
                                           ready_rptr_reg};
        default: rdata_reg <= 16'h0000;
      endcase
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  // Async flags are software-owned; they travel out with the options and in bit 13 of the read-only pointers.
  // The reassembly logic reads these levels every cell; they change only on
  // a register write, so software should alter them while reception is idle.
  assign OPTS_O = '{non_assured_delivery: base_opt_reg[`RXQ_BIT_NON_ASSURED],
                    first_cell_stream_irq: base_opt_reg[`RXQ_BIT_FIRST_CELL_IRQ],
                    reads_async_to_dma_clock: base_opt_reg[`RXQ_BIT_ASYNC_DMA],
                    reads_async_to_rx_clock: base_opt_reg[`RXQ_BIT_ASYNC_RX],
                    keep_nonzero_mux_id_cells: base_opt_reg[`RXQ_BIT_KEEP_MID]};

  // Trailer delivery on CRC failure only in non-assured mode.
  // A trailer with a good CRC is always delivered; only a failed one needs the option.
  assign TRAILER_DMA_EN_O = TRAILER_CELL_I &&
                            (!CRC_FAIL_I || base_opt_reg[`RXQ_BIT_NON_ASSURED]);
  // Non-zero MID cells are dropped unless the keep bit is set.
  // Other cell types, or a zero MID, never depend on the keep bit.
  // The level follows the cell attributes in the same cycle.
  assign CELL_DISCARD_O = AAL34_CELL_I && MID_NONZERO_I &&
                          !base_opt_reg[`RXQ_BIT_KEEP_MID];

  // Every data output comes straight from a flip-flop; only the trailer and
  // discard levels are combinational, since they qualify the current cell.
  assign REG_RDATA_O = rdata_reg;
  assign MEM_RD_O = mem_rd_reg;
  assign MEM_WR_O = mem_wr_reg;
  assign MEM_ADDR_O = mem_addr_reg;
  assign MEM_WDATA_O = mem_wdata_reg;
  assign FETCH_VALID_O = fetch_valid_reg;
  assign FETCH_NONE_O = fetch_none_reg;
  assign FETCH_DESC_ADDR_O = fetch_addr_reg;
  assign READY_WRITE_IRQ_O = irq_reg;
  assign READY_FULL_O = ready_full_reg;
endmodule

// ===== rxq_checker.sv
/*
  Port checker for the receive queue address block.
  Assumes it is bound into the top module, one clock, active-low reset.
*/
`timescale 1ns/1ps
module rxq_checker (
  // Clock, reset and request inputs.
  input wire logic CLK_SYS_I,
  input wire logic RST_B_I,
  input wire logic PACKET_DONE_I,
  input wire logic FIRST_CELL_DONE_I,
  input wire logic [11:0] DONE_DESC_IDX_I,
  input wire logic CRC_FAIL_I,
  input wire logic TRAILER_CELL_I,
  input wire logic MID_NONZERO_I,
  input wire logic AAL34_CELL_I,
  input wire logic MEM_RVALID_I,
  // Outputs watched.
  input wire logic MEM_RD_O,
  input wire logic MEM_WR_O,
  input wire logic [23:0] MEM_ADDR_O,
  input wire logic [15:0] MEM_WDATA_O,
  input wire logic FETCH_VALID_O,
  input wire logic FETCH_NONE_O,
  input wire logic READY_WRITE_IRQ_O,
  input wire logic READY_FULL_O,
  input wire logic TRAILER_DMA_EN_O,
  input wire logic CELL_DISCARD_O,
  input wire rxq_pkg::rx_opts_type OPTS_O
);
  import rxq_pkg::*;
  // Every check runs on the one clock and is silenced during reset.
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!RST_B_I);
  addr_align_a: assert property ((MEM_RD_O || MEM_WR_O) |-> !MEM_ADDR_O[0])
    else $error("queue entry address is odd");
  post_write_a: assert property (PACKET_DONE_I && !READY_FULL_O |=> MEM_WR_O
    && MEM_WDATA_O == {4'h0, $past(DONE_DESC_IDX_I)}) else $error("post not written");
  post_irq_a: assert property (READY_WRITE_IRQ_O == MEM_WR_O)
    else $error("ready interrupt not paired with its post");
  full_drop_a: assert property (READY_FULL_O && PACKET_DONE_I && !FIRST_CELL_DONE_I
    |=> !MEM_WR_O) else $error("post written into a full queue");
  first_off_a: assert property (FIRST_CELL_DONE_I && !PACKET_DONE_I
    && !OPTS_O.first_cell_stream_irq |=> !MEM_WR_O) else $error("first cell posted");
  fetch_answer_a: assert property (MEM_RD_O |-> ##[1:20] FETCH_VALID_O)
    else $error("entry read without fetch result");
  desc_valid_a: assert property (MEM_RVALID_I |=> FETCH_VALID_O && !FETCH_NONE_O)
    else $error("entry data not turned into a descriptor");
  trailer_na_a: assert property (TRAILER_CELL_I && CRC_FAIL_I
    |-> TRAILER_DMA_EN_O == OPTS_O.non_assured_delivery) else $error("trailer dma wrong");
  mid_keep_a: assert property (AAL34_CELL_I && MID_NONZERO_I
    |-> CELL_DISCARD_O == !OPTS_O.keep_nonzero_mux_id_cells) else $error("mid discard wrong");
  // Main scenarios reached.
  post_c: cover property (MEM_WR_O);
  fetch_c: cover property (FETCH_VALID_O);
  none_c: cover property (FETCH_NONE_O);
  full_c: cover property (READY_FULL_O && PACKET_DONE_I);
endmodule

// ===== rxq_defs.svh
/*
  Register indices, field positions, reset values and widths for the receive
  queue address block. Assumes it is included by bare name into the package;
  the design file has no include of its own and uses the macros from there.
*/
`ifndef RXQ_DEFS_SVH
`define RXQ_DEFS_SVH

// Register indices on the control port.
`define RXQ_IDX_BASE_OPT 6'h28
`define RXQ_IDX_FREE_START 6'h29
`define RXQ_IDX_FREE_END 6'h2a
`define RXQ_IDX_FREE_WPTR 6'h2b
`define RXQ_IDX_FREE_RPTR 6'h2c
`define RXQ_IDX_DESC_BASE 6'h2d
`define RXQ_IDX_READY_START 6'h2e
`define RXQ_IDX_READY_END 6'h2f
`define RXQ_IDX_READY_WPTR 6'h30
`define RXQ_IDX_READY_RPTR 6'h31

// Option bits of the base register.
`define RXQ_BIT_NON_ASSURED 15
`define RXQ_BIT_FIRST_CELL_IRQ 14
`define RXQ_BIT_ASYNC_DMA 13
`define RXQ_BIT_ASYNC_RX 12
`define RXQ_BIT_KEEP_MID 11

// Pointer register flag bits.
`define RXQ_BIT_AUTO_INC 15
`define RXQ_BIT_EMPTY 14
`define RXQ_BIT_FULL 13
`define RXQ_BIT_ASYNC_IND 13

// Field widths and address shifts.
`define RXQ_BASE_W 10
`define RXQ_OFS_W 13
`define RXQ_BASE_SHIFT 14
`define RXQ_OFS_SHIFT 1
`define RXQ_DESC_SHIFT 8
`define RXQ_IDX_SHIFT 5
`define RXQ_ADDR_W 24

// Reset values.
`define RXQ_RESET_WORD 16'h0000
`define RXQ_RESET_OFS 13'h0000

`endif

// ===== rxq_mem_model.sv
/*
  Queue memory model: answers each entry read after a lag the bench sets.
  Assumes one read outstanding at a time.
*/
`timescale 1ns/1ps
module rxq_mem_model (
  // Clock, reset and lag.
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [3:0] lag_i,
  // Entry read port.
  input wire logic rd_i,
  input wire logic [23:0] addr_i,
  output logic rvalid_o,
  output logic [15:0] rdata_o
);
  logic [3:0] wait_reg;
  logic busy_reg;
  logic [11:0] idx_reg;
  // Entry content scrambles the address; idle data toggles so that a late
  // sample of the bus shows garbage rather than the last answer.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wait_reg <= 4'h0;
      busy_reg <= 1'b0;
      idx_reg <= 12'h000;
      rvalid_o <= 1'b0;
      rdata_o <= 16'h0000;
    end else if (rd_i) begin
      busy_reg <= 1'b1;
      wait_reg <= lag_i;
      idx_reg <= addr_i[12:1] ^ 12'h5a5;
      rvalid_o <= 1'b0;
      rdata_o <= ~rdata_o;
    end else if (busy_reg && wait_reg == 4'h0) begin
      busy_reg <= 1'b0;
      rvalid_o <= 1'b1;
      rdata_o <= {4'h0, idx_reg};
    end else begin
      wait_reg <= (wait_reg == 4'h0) ? 4'h0 : wait_reg - 4'h1;
      rvalid_o <= 1'b0;
      rdata_o <= ~rdata_o;
    end
  end
endmodule

// ===== rxq_pkg.sv
/*
  Types shared by the receive queue address block. Assumes rxq_defs.svh is
  on the include path.
*/
package rxq_pkg;
  `include "rxq_defs.svh"

  // Control register port request.
  typedef struct packed {
    logic [5:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  // Receive option bits as seen by the reassembly logic.
  typedef struct packed {
    logic non_assured_delivery;
    logic first_cell_stream_irq;
    logic reads_async_to_dma_clock;
    logic reads_async_to_rx_clock;
    logic keep_nonzero_mux_id_cells;
  } rx_opts_type;

  // Fetch sequencing of the free queue.
  typedef enum logic [1:0] {
    FETCH_IDLE,
    FETCH_ADDR,
    FETCH_WAIT
  } fetch_state_type;
endpackage

// ===== tb_top.sv
/*
  Testbench for the receive queue address block: control port tasks, fetch
  and post sequences. Assumes the design package and the memory model.
*/
`timescale 1ns/1ps
module tb_top;
  import rxq_pkg::*;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  reg_req_type req = '0;
  logic fetch_req = 1'b0, done = 1'b0, first = 1'b0;
  logic crc = 1'b0, trl = 1'b0, midnz = 1'b0, aal34 = 1'b0;
  logic [11:0] didx = 12'h000;
  logic [3:0] lag = 4'h0;
  logic mem_rd, mem_wr, rvalid, f_valid, f_none, irq, rfull, trl_en, disc;
  logic [23:0] maddr, fdesc;
  logic [15:0] mwdata, rdata, mrdata;
  rx_opts_type opts;
  int err_count = 0, samples_checked = 0, cycles = 0;
  rx_queue_address_pointers dut (.CLK_SYS_I(clk), .RST_B_I(rst_b), .REG_REQ_I(req),
    .REG_RDATA_O(rdata), .FETCH_REQ_I(fetch_req), .PACKET_DONE_I(done),
    .FIRST_CELL_DONE_I(first), .DONE_DESC_IDX_I(didx), .CRC_FAIL_I(crc),
    .TRAILER_CELL_I(trl), .MID_NONZERO_I(midnz), .AAL34_CELL_I(aal34), .MEM_RD_O(mem_rd),
    .MEM_WR_O(mem_wr), .MEM_ADDR_O(maddr), .MEM_WDATA_O(mwdata), .MEM_RVALID_I(rvalid),
    .MEM_RDATA_I(mrdata), .FETCH_VALID_O(f_valid), .FETCH_NONE_O(f_none),
    .FETCH_DESC_ADDR_O(fdesc), .READY_WRITE_IRQ_O(irq), .READY_FULL_O(rfull),
    .TRAILER_DMA_EN_O(trl_en), .CELL_DISCARD_O(disc), .OPTS_O(opts));
  rxq_mem_model mem (.clk_i(clk), .rst_b_i(rst_b), .lag_i(lag), .rd_i(mem_rd),
    .addr_i(maddr), .rvalid_o(rvalid), .rdata_o(mrdata));
  // Clock at 40 MHz.
  initial forever #12.5 clk = ~clk;
  task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Each access task starts right after an edge and ends on one.
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    req <= '0;
    #1;
    chk($sformatf("register %h", a), {8'h00, rdata}, {8'h00, e});
    @(posedge clk);
  endtask
  task automatic post(input logic fc, input logic [11:0] i, input logic ew, input logic [12:0] p);
    first <= fc;
    done <= !fc;
    didx <= i;
    @(posedge clk);
    first <= 1'b0;
    done <= 1'b0;
    #1;
    chk("post write", mem_wr, ew);
    if (ew) begin
      chk("post addr", maddr, {10'h123, p, 1'b0});
      chk("post data", mwdata, {4'h0, i});
      chk("post irq", irq, 1'b1);
    end
    @(posedge clk);
  endtask
  // The bench waits a bounded time, since the start latency may vary.
  task automatic fetch(input logic none, input logic [12:0] p, input logic [3:0] l);
    int n;
    n = 0;
    lag <= l;
    fetch_req <= 1'b1;
    @(posedge clk);
    fetch_req <= 1'b0;
    #1;
    while ((none ? f_none : mem_rd) !== 1'b1 && n < 4) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("fetch start", none ? f_none : mem_rd, 1'b1);
    if (!none) begin
      chk("fetch addr", maddr, {10'h123, p, 1'b0});
      n = 0;
      while (f_valid !== 1'b1 && n < 20) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk("fetch desc", fdesc, 24'h0abc00 + {7'h00, p[11:0] ^ 12'h5a5, 5'h00});
    end
    @(posedge clk);
  endtask
  // A hang is cut short and reported as a mismatch.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    trl <= 1'b1;
    crc <= 1'b1;
    aal34 <= 1'b1;
    midnz <= 1'b1;
    @(posedge clk);
    wr(6'h28, 16'hfd23);
    #1;
    chk("options", opts, 5'h1f);
    chk("trailer dma on", trl_en, 1'b1);
    chk("cell kept", disc, 1'b0);
    @(posedge clk);
    rd(6'h28, 16'hf923);
    wr(6'h28, 16'h0123);
    #1;
    chk("trailer dma off", trl_en, 1'b0);
    chk("cell dropped", disc, 1'b1);
    @(posedge clk);
    rd(6'h00, 16'h0000);
    $display("test options done");
    wr(6'h29, 16'h0004);
    wr(6'h2a, 16'h0005);
    wr(6'h2d, 16'h0abc);
    rd(6'h2a, 16'h0005);
    rd(6'h2b, 16'h4004);
    wr(6'h2c, 16'h0001);
    rd(6'h2c, 16'h0004);
    fetch(1'b1, 13'h0000, 4'h0);
    wr(6'h2b, 16'h8000);
    wr(6'h2b, 16'h8000);
    rd(6'h2b, 16'h2004);
    fetch(1'b0, 13'h0004, 4'h0);
    fetch(1'b0, 13'h0005, 4'h4);
    rd(6'h2c, 16'h0004);
    fetch(1'b1, 13'h0000, 4'h0);
    $display("test free queue done");
    wr(6'h2e, 16'h0010);
    wr(6'h2f, 16'h0011);
    post(1'b0, 12'h111, 1'b1, 13'h0010);
    post(1'b1, 12'h222, 1'b0, 13'h0000);
    wr(6'h28, 16'h4123);
    post(1'b1, 12'h222, 1'b1, 13'h0011);
    chk("ready full", rfull, 1'b1);
    post(1'b0, 12'h333, 1'b0, 13'h0000);
    wr(6'h31, 16'h8000);
    post(1'b0, 12'h333, 1'b1, 13'h0010);
    rd(6'h30, 16'h0011);
    rd(6'h31, 16'h2011);
    $display("test ready queue done");
    print_verdict();
  end
endmodule
bind rx_queue_address_pointers rxq_checker chk_inst (.*);
